// *** rtl/fbr_array_mem.sv ***
// word array: loaded on the system clock, read on the link clock
module fbr_array_mem
  import fbr_pkg::*;
(
  input wire logic clk,
  input wire logic link_clk,
  fbr_mem_if.array mem
);
  logic [DATA_W-1:0] words_q [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] rd_data_q;

  always_ff @(posedge clk) begin
    if (mem.wr_en) begin
      words_q[mem.wr_addr] <= mem.wr_data;
    end
  end

  // loading and reading the same word at once is not supported
  always_ff @(posedge link_clk) begin
    if (mem.rd_en) begin
      rd_data_q <= words_q[mem.rd_addr];
    end
  end

  assign mem.rd_data = rd_data_q;
endmodule

// *** rtl/fbr_mem_if.sv ***
// carrier between the burst engine and the array memory
interface fbr_mem_if;
  import fbr_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  modport engine (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
  modport array (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface

// *** rtl/fbr_pkg.sv ***
// constants shared by the read burst port and its array memory
package fbr_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CFG_W = 8;

  // configuration byte layout
  localparam int CFG_LAT_MSB = 7;
  localparam int CFG_LAT_LSB = 4;
  localparam int CFG_HYB_BIT = 2;
  localparam int CFG_WRAP_MSB = 1;
  localparam int CFG_WRAP_LSB = 0;

  localparam logic [3:0] LAT_CODE_MAX = 4'hB;
  localparam logic [3:0] NV_DEFAULT_LAT_CODE = 4'hB;
  localparam logic [CFG_W-1:0] NV_DEFAULT_CFG = 8'hB0;

  // latency and page figures in link clocks or words
  localparam logic [5:0] LAT_BASE = 6'h05;
  localparam logic [5:0] LAT_START_CYC = 6'h02;
  localparam logic [5:0] PAGE_WORDS = 6'h10;
  localparam logic [2:0] SUBPAGE_MASK = 3'h7;
  localparam logic [5:0] CYC_MAX = 6'h3F;

  // bit positions inside the command/address words: direction and burst in the first, word offset in the third
  localparam int CA_DIR_BIT = 15;
  localparam int CA_BURST_BIT = 13;
  localparam int CA_WORD_MSB = 2;

  // clock counts after chip select falls at which each command/address word is complete
  localparam logic [5:0] CA_FIRST_DONE = 6'h01;
  localparam logic [5:0] CA_SECOND_DONE = 6'h02;
  localparam logic [5:0] CA_THIRD_DONE = 6'h03;

  typedef enum logic [1:0] {
    FBR_WRAP_16B = 2'b00,
    FBR_WRAP_32B = 2'b01,
    FBR_WRAP_64B = 2'b10,
    FBR_WRAP_64X = 2'b11
  } fbr_wrap_type;

  localparam logic [ADDR_W-1:0] WRAP_MASK_16B = 10'h007;
  localparam logic [ADDR_W-1:0] WRAP_MASK_32B = 10'h00F;
  localparam logic [ADDR_W-1:0] WRAP_MASK_64B = 10'h01F;
endpackage

// *** rtl/fbr_read_port.sv ***
// read burst port of a ddr byte-wide serial nor flash
module fbr_read_port
  import fbr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic [BYTE_W-1:0] dq_i,
  output logic [BYTE_W-1:0] dq_o,
  output logic dq_oe,
  output logic read_data_strobe_o,
  output logic read_data_strobe_oe,
  input wire logic [CFG_W-1:0] nonvolatile_config_reg,
  input wire logic cfg_wr_en,
  input wire logic [CFG_W-1:0] cfg_wr_data,
  output logic [CFG_W-1:0] cfg_q_o,
  output logic busy_o,
  input wire logic load_en,
  input wire logic [ADDR_W-1:0] load_addr,
  input wire logic [DATA_W-1:0] load_data
);
  import fbr_pkg::*;

  fbr_mem_if mem_bus ();

  fbr_array_mem u_mem (
    .clk(clk),
    .link_clk(link_clk),
    .mem(mem_bus.array)
  );

  // ---------------- system clock side ----------------
  logic [CFG_W-1:0] cfg_q;
  logic busy_s1_q;
  logic busy_s2_q;

  // volatile copy loads the nonvolatile image at reset; reserved latency codes are never taken
  always_ff @(posedge clk) begin
    if (srst) begin
      if (nonvolatile_config_reg[CFG_LAT_MSB:CFG_LAT_LSB] > LAT_CODE_MAX) begin
        cfg_q <= {NV_DEFAULT_LAT_CODE, nonvolatile_config_reg[CFG_LAT_LSB-1:0]};
      end else begin
        cfg_q <= nonvolatile_config_reg;
      end
    end else if (cfg_wr_en && cfg_wr_data[CFG_LAT_MSB:CFG_LAT_LSB] <= LAT_CODE_MAX) begin
      cfg_q <= cfg_wr_data;
    end
  end

  assign cfg_q_o = cfg_q;

  logic read_q;

  // the read flag is a level, so two flops are enough to bring it over
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
    end else begin
      busy_s1_q <= read_q;
      busy_s2_q <= busy_s1_q;
    end
  end

  assign busy_o = busy_s2_q;

  assign mem_bus.wr_en = load_en;
  assign mem_bus.wr_addr = load_addr;
  assign mem_bus.wr_data = load_data;

  // ---------------- link clock side ----------------
  // configuration is quasi static: change it only while no transaction runs
  logic [CFG_W-1:0] cfg_s1_q;
  logic [CFG_W-1:0] cfg_s2_q;
  logic [CFG_W-1:0] cfg_s3_q;
  logic [CFG_W-1:0] cfg_lk_q;

  always_ff @(posedge link_clk) begin
    cfg_s1_q <= cfg_q;
    cfg_s2_q <= cfg_s1_q;
    cfg_s3_q <= cfg_s2_q;
  end

  // a byte caught mid-change can mix old and new bits, so only two equal samples in a row are taken
  always_ff @(posedge link_clk) begin
    if (cfg_s2_q == cfg_s3_q) begin
      cfg_lk_q <= cfg_s2_q;
    end
  end

  logic [5:0] lat_clocks;
  logic [5:0] first_data_cyc;
  logic [ADDR_W-1:0] wrap_mask;
  logic [5:0] wrap_words;
  logic hybrid_sel;
  logic wrap_long;

  always_comb begin
    lat_clocks = LAT_BASE + {2'b00, cfg_lk_q[CFG_LAT_MSB:CFG_LAT_LSB]};
    first_data_cyc = LAT_START_CYC + lat_clocks;
    hybrid_sel = cfg_lk_q[CFG_HYB_BIT];
    wrap_long = 1'b0;
    case (fbr_wrap_type'(cfg_lk_q[CFG_WRAP_MSB:CFG_WRAP_LSB]))
      FBR_WRAP_16B: begin
        wrap_mask = WRAP_MASK_16B;
      end
      FBR_WRAP_32B: begin
        wrap_mask = WRAP_MASK_32B;
      end
      FBR_WRAP_64B, FBR_WRAP_64X: begin
        wrap_mask = WRAP_MASK_64B;
        wrap_long = 1'b1;
      end
      default: begin
        wrap_mask = WRAP_MASK_16B;
      end
    endcase
    wrap_words = 6'(wrap_mask) + 6'h01;
  end

  // chip select high clears every frame register at once, so bus and strobe drop immediately
  logic [5:0] cyc_q;
  logic [BYTE_W-1:0] hi_q;
  logic [BYTE_W-1:0] lo_q;
  logic [DATA_W-1:0] ca_first_q;
  logic [DATA_W-1:0] ca_second_q;
  logic armed_q;
  logic linear_q;
  logic addr_valid_q;
  logic [ADDR_W-1:0] addr_q;
  logic [2:0] start_off_q;
  logic start_b3_q;
  logic go_q;
  logic oe_q;
  logic [5:0] wcnt_q;
  logic hyb_done_q;
  logic crossed_q;
  logic [5:0] wait_q;

  always_ff @(posedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      cyc_q <= 6'h00;
      hi_q <= 8'h00;
    end else begin
      hi_q <= dq_i;
      if (cyc_q != CYC_MAX) begin
        cyc_q <= cyc_q + 6'h01;
      end
    end
  end

  // low bytes of the command words arrive on the falling clock
  always_ff @(negedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      lo_q <= 8'h00;
    end else begin
      lo_q <= dq_i;
    end
  end

  // command/address decode
  always_ff @(posedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      ca_first_q <= 16'h0000;
      ca_second_q <= 16'h0000;
      read_q <= 1'b0;
      linear_q <= 1'b0;
      armed_q <= 1'b0;
      addr_valid_q <= 1'b0;
      start_off_q <= 3'h0;
      start_b3_q <= 1'b0;
    end else begin
      if (cyc_q == CA_FIRST_DONE) begin
        ca_first_q <= {hi_q, lo_q};
        read_q <= hi_q[CA_DIR_BIT-BYTE_W];
        linear_q <= hi_q[CA_BURST_BIT-BYTE_W];
      end
      if (cyc_q == CA_SECOND_DONE) begin
        ca_second_q <= {hi_q, lo_q};
        armed_q <= read_q;
      end
      if (cyc_q == CA_THIRD_DONE) begin
        addr_valid_q <= armed_q;
        start_off_q <= lo_q[CA_WORD_MSB:0] & SUBPAGE_MASK;
        start_b3_q <= ca_second_q[0];
      end
    end
  end

  // wait clocks owed at the first page crossing
  logic [5:0] off_plus_lat;
  logic [5:0] cross_waits;
  logic linear_eff;
  logic page_cross_mode;
  logic at_page_end;

  always_comb begin
    off_plus_lat = {3'b000, start_off_q} + lat_clocks;
    if (off_plus_lat > PAGE_WORDS) begin
      cross_waits = off_plus_lat - PAGE_WORDS;
    end else begin
      cross_waits = 6'h00;
    end
    linear_eff = linear_q | hyb_done_q;
    page_cross_mode = linear_eff | wrap_long;
    // the crossing lies 16 words past the start's 8-word group, so an upper-half start waits one group later
    at_page_end = (addr_q[2:0] == 3'h7) && (addr_q[3] != start_b3_q);
  end

  // next word address
  logic [ADDR_W-1:0] addr_inc;
  logic [ADDR_W-1:0] addr_next;
  logic hyb_switch;

  always_comb begin
    addr_inc = addr_q + 10'h001;
    hyb_switch = !linear_q && hybrid_sel && !hyb_done_q && (wcnt_q == wrap_words - 6'h01);
    if (linear_eff) begin
      addr_next = addr_inc;
    end else if (hyb_switch) begin
      addr_next = (addr_q & ~wrap_mask) + {4'h0, wrap_words};
    end else begin
      addr_next = (addr_q & ~wrap_mask) | (addr_inc & wrap_mask);
    end
  end

  // burst engine: one word per clock while the host keeps the clock running, except for the wait clocks at the first page crossing
  always_ff @(posedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      addr_q <= 10'h000;
      oe_q <= 1'b0;
      wcnt_q <= 6'h00;
      hyb_done_q <= 1'b0;
      crossed_q <= 1'b0;
      wait_q <= 6'h00;
    end else begin
      if (cyc_q == CA_THIRD_DONE) begin
        addr_q <= {ca_second_q[ADDR_W-4:0], lo_q[CA_WORD_MSB:0]};
      end else if (go_q) begin
        oe_q <= 1'b1;
        addr_q <= addr_next;
        if (wcnt_q != CYC_MAX) begin
          wcnt_q <= wcnt_q + 6'h01;
        end
        if (hyb_switch) begin
          hyb_done_q <= 1'b1;
        end
        if (page_cross_mode && at_page_end && !crossed_q) begin
          crossed_q <= 1'b1;
          wait_q <= cross_waits;
        end
      end else if (oe_q && wait_q != 6'h00) begin
        wait_q <= wait_q - 6'h01;
      end
    end
  end

  // decided on the falling edge so the strobe gate never changes while the clock is high
  logic go_next;

  always_comb begin
    go_next = addr_valid_q && (cyc_q >= first_data_cyc) && (wait_q == 6'h00);
  end

  always_ff @(negedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      go_q <= 1'b0;
    end else begin
      go_q <= go_next;
    end
  end

  assign mem_bus.rd_en = go_q;
  assign mem_bus.rd_addr = addr_q;

  // ddr output stage: the strobe is the gated link clock, edge aligned with the byte mux
  always_comb begin
    read_data_strobe_o = link_clk & go_q;
    read_data_strobe_oe = oe_q;
    dq_oe = oe_q;
    if (link_clk) begin
      dq_o = mem_bus.rd_data[15:8];
    end else begin
      dq_o = mem_bus.rd_data[7:0];
    end
  end
endmodule

// *** testbench/fbr_host_model.sv ***
// host controller model: select, link clock, command words
module fbr_host_model
  import fbr_pkg::*;
(
  output logic link_clk,
  output logic cs_n,
  output logic [BYTE_W-1:0] dq_i,
  input wire logic [BYTE_W-1:0] dq_o,
  input wire logic read_data_strobe_o
);
  timeunit 1ns;
  timeprecision 10ps;
  logic [15:0] got[$];
  int first;
  initial begin
    link_clk = 1'h0;
    cs_n = 1'h1;
    dq_i = 8'h00;
  end
  // clock runs only inside the frame; dq changes mid-phase (center aligned)
  task automatic frame(input logic [47:0] ca, input int n);
    logic [7:0] hi;
    logic s;
    got.delete();
    first = -1;
    dq_i = ca[47:40];
    #3.75 cs_n = 1'h0;
    for (int k = 0; k < n; k++) begin
      #3.75 link_clk = 1'h1;
      #3.75 s = read_data_strobe_o;
      hi = dq_o;
      dq_i = k < 3 ? ca[39-16*k-:8] : ~dq_i;
      if (s && first < 0) first = k;
      #3.75 link_clk = 1'h0;
      #3.75 if (s) got.push_back({hi, dq_o});
      dq_i = k < 2 ? ca[31-16*k-:8] : ~dq_i;
    end
    cs_n = 1'h1;
    dq_i = ~dq_i;
  endtask
endmodule

// *** testbench/fbr_monitor.sv ***
// assertion checker for the read burst port
module fbr_monitor
  import fbr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic [BYTE_W-1:0] dq_i,
  input wire logic dq_oe,
  input wire logic read_data_strobe_o,
  input wire logic read_data_strobe_oe,
  input wire logic [CFG_W-1:0] nonvolatile_config_reg,
  input wire logic cfg_wr_en,
  input wire logic [CFG_W-1:0] cfg_wr_data,
  input wire logic [CFG_W-1:0] cfg_q_o
);
  timeunit 1ns;
  timeprecision 10ps;
  logic [5:0] cnt_q;
  logic rd_q;
  logic lin_q;
  logic [5:0] lat;
  logic [3:0] nv_lat;
  assign lat = LAT_BASE + 6'(cfg_q_o[CFG_LAT_MSB:CFG_LAT_LSB]);
  assign nv_lat = nonvolatile_config_reg[7:4] > LAT_CODE_MAX ? LAT_CODE_MAX : nonvolatile_config_reg[7:4];
  // deselect clears the count, as it clears the frame logic
  always_ff @(posedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= 6'h00;
      rd_q <= 1'h0;
      lin_q <= 1'h0;
    end else begin
      cnt_q <= cnt_q == CYC_MAX ? cnt_q : cnt_q + 6'h01;
      if (cnt_q == 6'h00) begin
        rd_q <= dq_i[CA_DIR_BIT-BYTE_W];
        lin_q <= dq_i[CA_BURST_BIT-BYTE_W];
      end
    end
  end
  oe_pair_a: assert property (@(posedge clk) disable iff (srst) dq_oe == read_data_strobe_oe)
    else $error("enables differ");
  release_a: assert property (@(posedge clk) disable iff (srst) cs_n |-> !dq_oe && !read_data_strobe_o)
    else $error("driving while deselected");
  strobe_oe_a: assert property (@(posedge clk) disable iff (srst) read_data_strobe_o |-> dq_oe)
    else $error("strobe without enable");
  cfg_write_a: assert property (@(posedge clk) disable iff (srst)
    cfg_wr_en && cfg_wr_data[7:4] <= LAT_CODE_MAX |=> cfg_q_o == $past(cfg_wr_data)) else $error("cfg not written");
  cfg_refuse_a: assert property (@(posedge clk) disable iff (srst)
    cfg_wr_en && cfg_wr_data[7:4] > LAT_CODE_MAX |=> $stable(cfg_q_o)) else $error("reserved code taken");
  cfg_reset_a: assert property (@(posedge clk)
    srst |=> cfg_q_o == {$past(nv_lat), $past(nonvolatile_config_reg[3:0])}) else $error("cfg reset value");
  oe_start_a: assert property (@(negedge link_clk) disable iff (cs_n)
    cnt_q > 6'h02 |-> dq_oe == (rd_q && cnt_q > lat + LAT_START_CYC)) else $error("enable timing");
  strobe_start_a: assert property (@(negedge link_clk) disable iff (cs_n)
    rd_q && cnt_q == lat + 6'h03 |-> read_data_strobe_o) else $error("first strobe late");
  wrap_nowait_a: assert property (@(negedge link_clk) disable iff (cs_n)
    rd_q && !lin_q && cfg_q_o[2:1] == 2'h0 && cnt_q > lat + 6'h02 |-> read_data_strobe_o) else $error("wrap waited");
endmodule
bind fbr_read_port fbr_monitor u_mon (.*);

// *** testbench/testbench.sv ***
// self-checking bench for the read burst port
module testbench;
  import fbr_pkg::*;
  timeunit 1ns;
  timeprecision 10ps;
  logic clk, srst, link_clk, cs_n, dq_oe, read_data_strobe_o, read_data_strobe_oe, cfg_wr_en, busy_o, load_en;
  logic [7:0] dq_i, dq_o, nonvolatile_config_reg, cfg_wr_data, cfg_q_o;
  logic [9:0] load_addr;
  logic [15:0] load_data;
  logic [15:0] mem[1024];
  int errors, num_checks, seed, c;
  fbr_read_port u_dut (.*);
  fbr_host_model u_host (.*);
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic set_cfg(input logic [7:0] v);
    @(posedge clk) #1;
    cfg_wr_en = 1'h1;
    cfg_wr_data = v;
    @(posedge clk) #1;
    cfg_wr_en = 1'h0;
  endtask
  // reference: address per slot, -1 marks a page-crossing wait clock
  task automatic run(input logic [7:0] cfg, input logic rd, lin, input logic [9:0] a, input int d);
    int lat, g, w, i, ad, crossed;
    int q[$];
    lat = 5 + cfg[7:4];
    g = cfg[1] ? 32 : (cfg[0] ? 16 : 8);
    crossed = 0;
    set_cfg(cfg);
    u_host.frame({rd, 1'h0, lin, 13'h0, 9'h0, a[9:3], 13'h0, a[2:0]}, 2 + lat + d);
    for (i = 0; q.size() < d; i++) begin
      if (lin) ad = (a + i) % 1024;
      else if (cfg[2] && i >= g) ad = (a & ~(g - 1)) + i;
      else ad = (a & ~(g - 1)) | ((a + i) & (g - 1));
      q.push_back(ad);
      if ((ad & 7) == 7 && ((ad ^ a) & 8) != 0 && crossed == 0 && (lin || cfg[1] || (cfg[2] && i >= g))) begin
        crossed = 1;
        for (w = (a & 7) + lat - 16; w > 0; w--) q.push_back(-1);
      end
    end
    chk("first strobe", rd ? 2 + lat : -1, u_host.first);
    i = 0;
    for (w = 0; w < d; w++) begin
      if (q[w] >= 0 && rd) begin
        chk("word", mem[q[w]], u_host.got[i]);
        i++;
      end
    end
    chk("word count", i, u_host.got.size());
    #1 chk("release", 0, {dq_oe, read_data_strobe_oe});
    chk("busy", rd, busy_o);
    #10 chk("idle", 0, busy_o);
  endtask
  initial begin
    seed = 32'h70B6B12F;
    srst = 1'h1;
    cfg_wr_en = 1'h0;
    cfg_wr_data = 8'h00;
    load_en = 1'h0;
    load_addr = 10'h000;
    load_data = 16'h0000;
    nonvolatile_config_reg = NV_DEFAULT_CFG;
    repeat (3) @(posedge clk);
    #1 srst = 1'h0;
    chk("cfg reset", NV_DEFAULT_CFG, cfg_q_o);
    for (c = 0; c < 1024; c++) begin
      @(posedge clk) #1;
      load_en = 1'h1;
      load_addr = 10'(c);
      load_data = 16'($random(seed));
      mem[c] = load_data;
    end
    @(posedge clk) #1 load_en = 1'h0;
    // 15 ns link clock allows codes of 2 and up only
    for (c = 2; c < 12; c++) run({c[3:0], 4'h0}, 1, 1, 10'($random(seed)), 24);
    for (c = 0; c < 4; c++) run({6'h2C, c[1:0]}, 1, 0, 10'($random(seed)), 40);
    run(8'hB4, 1, 0, 10'($random(seed)) & 10'h3F7, 16);
    run(8'hB0, 1, 1, 10'h3F8, 24);
    run(8'hB0, 0, 1, 10'($random(seed)), 8);
    run(8'h70, 1, 1, 10'($random(seed)), 3);
    set_cfg(8'h70);
    set_cfg(8'hC5);
    chk("cfg refuse", 8'h70, cfg_q_o);
    nonvolatile_config_reg = 8'hF3;
    srst = 1'h1;
    @(posedge clk) #1 srst = 1'h0;
    chk("cfg fallback", 8'hB3, cfg_q_o);
    end_sim();
  end
  initial begin
    #100000;
    errors++;
    end_sim();
  end
endmodule
